// file: hw/slp_consts.svh
// Register offsets, reset values and scaling constants of the slider block
`ifndef SLP_CONSTS_SVH
`define SLP_CONSTS_SVH
`define SLP_OFS_HYST 8'h29
`define SLP_OFS_NORM_HI 8'h2B
`define SLP_OFS_NORM_LO 8'h2C
`define SLP_OFS_AVG 8'h2D
`define SLP_OFS_NEG 8'h2E
`define SLP_OFS_CNT 8'h2F
`define SLP_OFS_MOVE 8'h30
`define SLP_OFS_POS_HI 8'h31
`define SLP_OFS_POS_LO 8'h32
`define SLP_RST_HYST 8'h03
`define SLP_RST_NORM 16'h0180
`define SLP_RST_AVG 8'h50
`define SLP_RST_NEG 8'h50
`define SLP_RST_CNT 8'h01
`define SLP_RST_MOVE 8'h02
`define SLP_THR_ZEROS 2'b00
`define SLP_NORM_SHIFT 5
`define SLP_NORM_W 11
`define SLP_PCT_FULL 8'h64
`endif

// file: hw/slp_pkg.sv
// Types shared by the slider position processing modules
package slp_pkg;
  typedef logic [7:0] slp_byte_t;
  typedef enum {SLP_IDLE, SLP_DIV} slp_state_t;
endpackage : slp_pkg

// file: hw/slp_div_if.sv
// Request and answer signals between slider logic and its divider
`timescale 1ns/100ps
`default_nettype none
interface slp_div_if #(parameter int NW = 36, parameter int DW = 19);
  logic start;
  logic [NW-1:0] dividend;
  logic [DW-1:0] divisor;
  logic done;
  logic [NW-1:0] quotient;
  modport master(output start, dividend, divisor, input done, quotient);
  modport slave(input start, dividend, divisor, output done, quotient);
endinterface : slp_div_if
`default_nettype wire

// file: hw/slp_divider.sv
// Sequential restoring divider, one quotient bit per clock
`timescale 1ns/100ps
`default_nettype none
module slp_divider #(
  parameter int NW = 36,
  parameter int DW = 19
) (
  input wire logic clk,
  input wire logic rstn,
  slp_div_if.slave div
);
  localparam int CW = $clog2(NW + 1);
  logic busy, next_busy;
  logic done, next_done;
  logic [CW-1:0] cnt, next_cnt;
  logic [NW-1:0] quo, next_quo;
  logic [DW-1:0] rem, next_rem;
  logic [DW-1:0] dvs, next_dvs;
  logic [DW:0] shifted;

  always_comb begin
    next_busy = busy;
    next_done = 1'b0;
    next_cnt = cnt;
    next_quo = quo;
    next_rem = rem;
    next_dvs = dvs;
    shifted = {rem, quo[NW-1]};
    if (div.start) begin
      next_busy = 1'b1;
      next_cnt = CW'(NW);
      next_quo = div.dividend;
      next_rem = '0;
      next_dvs = div.divisor;
    end else if (busy) begin
      if (shifted >= {1'b0, dvs}) begin
        next_rem = DW'(shifted - {1'b0, dvs});
        next_quo = {quo[NW-2:0], 1'b1};
      end else begin
        next_rem = shifted[DW-1:0];
        next_quo = {quo[NW-2:0], 1'b0};
      end
      next_cnt = CW'(cnt - 1'b1);
      if (cnt == CW'(1)) begin
        next_busy = 1'b0;
        next_done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      busy <= 1'b0;
      done <= 1'b0;
      cnt <= '0;
      quo <= '0;
      rem <= '0;
      dvs <= '0;
    end else begin
      busy <= next_busy;
      done <= next_done;
      cnt <= next_cnt;
      quo <= next_quo;
      rem <= next_rem;
      dvs <= next_dvs;
    end
  end

  assign div.done = done;
  assign div.quotient = quo;
endmodule : slp_divider
`default_nettype wire

// file: hw/slp_slider.sv
// Slider pressure, position, movement and compensation evaluation
// How it works
// R01 - Hold averaging while ticks exceed register times four
// R02 - Negative compensation threshold is register times four
// R03 - Count limit 1..255 samples, zero never programmed
// R04 - Movement threshold is percent, one per count
// R05 - Move flag only when step exceeds threshold
// R06 - Pressure sums excess ticks above sensor thresholds
// R07 - Released at zero pressure, touched above hysteresis
// R08 - Position is norm/32 times weighted mean index
// R09 - Norm is high byte followed by low byte
// R10 - Position held 16 bits, read as two bytes
// R11 - Position clamped between zero and norm/32*(N-1)
// R12 - Long run below negative threshold triggers compensation
// R13 - Touch hysteresis is register times four
// R14 - Scaling norm resets to 0x0180
// R15 - Rise sets move high, fall sets move low
`timescale 1ns/100ps
`default_nettype none
`include "slp_consts.svh"
module slp_slider #(
  parameter int N = 8,
  parameter int TW = 16
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic scanStrobe,
  input wire logic [N*TW-1:0] tickDiff,
  input wire logic [N*TW-1:0] sensorTouchThreshold,
  input wire slp_pkg::slp_byte_t regAddr,
  input wire slp_pkg::slp_byte_t regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output slp_pkg::slp_byte_t regRdData,
  output logic [TW+$clog2(N)-1:0] sliderTouchPressure,
  output logic [15:0] sliderFingerPosition,
  output logic sliderTouched,
  output logic moveHigh,
  output logic moveLow,
  output logic averagingHold,
  output logic compensationTrigger
);
  import slp_pkg::*;
  localparam int SW = TW + $clog2(N);
  localparam int WW = SW + $clog2(N);
  localparam int NW = WW + `SLP_NORM_W;
  localparam int PW = `SLP_NORM_W + $clog2(N);

  slp_byte_t hysteresis, averagingThreshold, negativeThreshold;
  slp_byte_t countLimit, movementThreshold;
  slp_byte_t normHigh, normLow;
  slp_byte_t next_hysteresis, next_averagingThreshold;
  slp_byte_t next_negativeThreshold, next_countLimit;
  slp_byte_t next_movementThreshold, next_normHigh, next_normLow;
  slp_byte_t next_regRdData;

  // Register writes and registered read-back
  always_comb begin
    next_hysteresis = hysteresis;
    next_averagingThreshold = averagingThreshold;
    next_negativeThreshold = negativeThreshold;
    next_countLimit = countLimit;
    next_movementThreshold = movementThreshold;
    next_normHigh = normHigh;
    next_normLow = normLow;
    next_regRdData = regRdData;
    if (regWrEn) begin
      case (regAddr)
        `SLP_OFS_HYST: next_hysteresis = regWrData;
        `SLP_OFS_NORM_HI: next_normHigh = regWrData;
        `SLP_OFS_NORM_LO: next_normLow = regWrData;
        `SLP_OFS_AVG: next_averagingThreshold = regWrData;
        `SLP_OFS_NEG: next_negativeThreshold = regWrData;
        `SLP_OFS_CNT: next_countLimit = regWrData;
        `SLP_OFS_MOVE: next_movementThreshold = regWrData;
        default: ;
      endcase
    end
    if (regRdEn) begin
      case (regAddr)
        `SLP_OFS_HYST: next_regRdData = hysteresis;
        `SLP_OFS_NORM_HI: next_regRdData = normHigh;
        `SLP_OFS_NORM_LO: next_regRdData = normLow;
        `SLP_OFS_AVG: next_regRdData = averagingThreshold;
        `SLP_OFS_NEG: next_regRdData = negativeThreshold;
        `SLP_OFS_CNT: next_regRdData = countLimit;
        `SLP_OFS_MOVE: next_regRdData = movementThreshold;
        `SLP_OFS_POS_HI: next_regRdData = sliderFingerPosition[15:8]; // R10
        `SLP_OFS_POS_LO: next_regRdData = sliderFingerPosition[7:0]; // R10
        default: next_regRdData = '0;
      endcase
    end
  end

  localparam logic [15:0] NORM_RST = `SLP_RST_NORM;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      hysteresis <= `SLP_RST_HYST;
      normHigh <= NORM_RST[15:8]; // R14
      normLow <= NORM_RST[7:0]; // R14
      averagingThreshold <= `SLP_RST_AVG;
      negativeThreshold <= `SLP_RST_NEG;
      countLimit <= `SLP_RST_CNT;
      movementThreshold <= `SLP_RST_MOVE;
      regRdData <= '0;
    end else begin
      hysteresis <= next_hysteresis;
      normHigh <= next_normHigh;
      normLow <= next_normLow;
      averagingThreshold <= next_averagingThreshold;
      negativeThreshold <= next_negativeThreshold;
      countLimit <= next_countLimit;
      movementThreshold <= next_movementThreshold;
      regRdData <= next_regRdData;
    end
  end

  // Derived thresholds and scaling
  logic [15:0] scalingNorm;
  logic [`SLP_NORM_W-1:0] normStep;
  logic [9:0] avgLimit, negLimit, hystLimit;
  logic [PW-1:0] positionUpperLimit;
  logic [PW+7:0] moveProduct;
  logic [PW-1:0] moveLimit;
  assign scalingNorm = {normHigh, normLow}; // R09
  assign normStep = scalingNorm[15:`SLP_NORM_SHIFT]; // R08
  assign avgLimit = {averagingThreshold, `SLP_THR_ZEROS}; // R01
  assign negLimit = {negativeThreshold, `SLP_THR_ZEROS}; // R02
  assign hystLimit = {hysteresis, `SLP_THR_ZEROS}; // R13
  assign positionUpperLimit = PW'(normStep * (N - 1)); // R11
  assign moveProduct = (PW + 8)'(positionUpperLimit * movementThreshold);
  assign moveLimit = PW'(moveProduct / `SLP_PCT_FULL); // R04

  // Per-sensor excess, weighted sums and threshold crossings
  logic [TW-1:0] excess [N];
  logic [SW-1:0] sumExcess;
  logic [WW-1:0] sumWeighted;
  logic anyAbove, anyBelow;
  logic signed [TW:0] tickX, thrX, avgX, negX;
  always_comb begin
    sumExcess = '0;
    sumWeighted = '0;
    anyAbove = 1'b0;
    anyBelow = 1'b0;
    tickX = '0;
    thrX = '0;
    avgX = $signed({{(TW-9){1'b0}}, avgLimit});
    negX = $signed((TW + 1)'(0) - {{(TW-9){1'b0}}, negLimit});
    for (int i = 0; i < N; i++) begin
      tickX = $signed({tickDiff[i*TW+TW-1], tickDiff[i*TW +: TW]});
      thrX = $signed({1'b0, sensorTouchThreshold[i*TW +: TW]});
      excess[i] = (tickX > thrX) ? TW'(tickX - thrX) : '0; // R06
      sumExcess = SW'(sumExcess + excess[i]); // R06
      sumWeighted = WW'(sumWeighted + WW'(excess[i]) * WW'(i)); // R08
      if (tickX > avgX) anyAbove = 1'b1; // R01
      if (tickX < negX) anyBelow = 1'b1; // R12
    end
  end

  slp_div_if #(.NW(NW), .DW(SW)) divBus();
  slp_state_t state, next_state;
  assign divBus.start = scanStrobe && (state == SLP_IDLE)
                        && (sumExcess != '0);
  assign divBus.dividend = NW'(normStep * sumWeighted); // R08
  assign divBus.divisor = sumExcess; // R08

  slp_divider #(.NW(NW), .DW(SW)) divUnit (
    .clk(clk),
    .rstn(rstn),
    .div(divBus)
  );

  logic [SW-1:0] next_sliderTouchPressure;
  logic [15:0] next_sliderFingerPosition, prevPosition, next_prevPosition;
  logic [15:0] newPosition;
  logic prevValid, next_prevValid;
  logic next_sliderTouched, next_moveHigh, next_moveLow;
  logic next_averagingHold, next_compensationTrigger;
  logic [7:0] negCount, next_negCount;
  logic [8:0] negCountInc;

  // Scan evaluation and position update
  always_comb begin
    next_state = state;
    next_sliderTouchPressure = sliderTouchPressure;
    next_sliderFingerPosition = sliderFingerPosition;
    next_prevPosition = prevPosition;
    next_prevValid = prevValid;
    next_sliderTouched = sliderTouched;
    next_moveHigh = moveHigh;
    next_moveLow = moveLow;
    next_averagingHold = averagingHold;
    next_compensationTrigger = 1'b0;
    next_negCount = negCount;
    negCountInc = {1'b0, negCount} + 9'h001;
    newPosition = (divBus.quotient > NW'(positionUpperLimit))
                  ? 16'(positionUpperLimit) : divBus.quotient[15:0]; // R11
    case (state)
      SLP_IDLE: begin
        if (scanStrobe) begin
          next_sliderTouchPressure = sumExcess; // R06
          if (sumExcess == '0) begin
            next_sliderTouched = 1'b0; // R07
            next_prevValid = 1'b0;
            next_moveHigh = 1'b0;
            next_moveLow = 1'b0;
          end else begin
            if (SW'(hystLimit) < sumExcess) next_sliderTouched = 1'b1; // R07
            next_state = SLP_DIV;
          end
          next_averagingHold = anyAbove; // R01
          if (anyBelow) begin
            if (negCountInc >= {1'b0, countLimit}) begin // R03
              next_compensationTrigger = 1'b1; // R12
              next_negCount = '0;
            end else begin
              next_negCount = negCountInc[7:0];
            end
          end else begin
            next_negCount = '0;
          end
        end
      end
      SLP_DIV: begin
        if (divBus.done) begin
          next_sliderFingerPosition = newPosition; // R10
          next_prevPosition = newPosition;
          next_prevValid = 1'b1;
          next_moveHigh = prevValid && (newPosition > prevPosition)
            && ((newPosition - prevPosition) > 16'(moveLimit)); // R05 R15
          next_moveLow = prevValid && (prevPosition > newPosition)
            && ((prevPosition - newPosition) > 16'(moveLimit)); // R05 R15
          next_state = SLP_IDLE;
        end
      end
      default: next_state = SLP_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state <= SLP_IDLE;
      sliderTouchPressure <= '0;
      sliderFingerPosition <= '0;
      prevPosition <= '0;
      prevValid <= 1'b0;
      sliderTouched <= 1'b0;
      moveHigh <= 1'b0;
      moveLow <= 1'b0;
      averagingHold <= 1'b0;
      compensationTrigger <= 1'b0;
      negCount <= '0;
    end else begin
      state <= next_state;
      sliderTouchPressure <= next_sliderTouchPressure;
      sliderFingerPosition <= next_sliderFingerPosition;
      prevPosition <= next_prevPosition;
      prevValid <= next_prevValid;
      sliderTouched <= next_sliderTouched;
      moveHigh <= next_moveHigh;
      moveLow <= next_moveLow;
      averagingHold <= next_averagingHold;
      compensationTrigger <= next_compensationTrigger;
      negCount <= next_negCount;
    end
  end
endmodule : slp_slider
`default_nettype wire

// file: testbench/slp_slider_props.sv
// Concurrent checks on the slider block ports
`timescale 1ns/100ps
`default_nettype none
module slp_slider_props #(
  parameter int N = 8,
  parameter int TW = 16
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic scanStrobe,
  input wire slp_pkg::slp_byte_t regAddr,
  input wire slp_pkg::slp_byte_t regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire slp_pkg::slp_byte_t regRdData,
  input wire logic [TW+$clog2(N)-1:0] sliderTouchPressure,
  input wire logic [15:0] sliderFingerPosition,
  input wire logic sliderTouched,
  input wire logic moveHigh,
  input wire logic moveLow,
  input wire logic compensationTrigger
);
  import slp_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  slp_byte_t hyst, nHi, nLo, next_hyst, next_nHi, next_nLo;
  logic [18:0] posMax;
  // Shadow of the registers that bound touch and position
  always_comb begin
    next_hyst = (regWrEn && regAddr == 8'h29) ? regWrData : hyst;
    next_nHi = (regWrEn && regAddr == 8'h2B) ? regWrData : nHi;
    next_nLo = (regWrEn && regAddr == 8'h2C) ? regWrData : nLo;
  end
  always_ff @(posedge clk) begin
    hyst <= rstn ? next_hyst : 8'h03;
    nHi <= rstn ? next_nHi : 8'h01;
    nLo <= rstn ? next_nLo : 8'h80;
  end
  assign posMax = 19'({nHi, nLo} >> 5) * 19'(N - 1);
  sequence posStep; $changed(sliderFingerPosition); endsequence
  sequence touchOn; $rose(sliderTouched); endsequence
  zero_released_a: assert property (
    sliderTouchPressure == '0 |-> !sliderTouched) else $error("touched at zero");
  touch_hyst_a: assert property (
    touchOn |-> sliderTouchPressure > {hyst, 2'b00}) else $error("touch low");
  move_excl_a: assert property (
    !(moveHigh && moveLow)) else $error("both move flags set");
  move_up_a: assert property (
    $rose(moveHigh) |-> sliderFingerPosition > $past(sliderFingerPosition))
    else $error("move high without rise");
  move_down_a: assert property (
    $rose(moveLow) |-> sliderFingerPosition < $past(sliderFingerPosition))
    else $error("move low without fall");
  pos_limit_a: assert property (
    sliderFingerPosition <= posMax) else $error("position above maximum");
  pos_timing_a: assert property (
    posStep |-> $past(scanStrobe, 35)) else $error("position update late");
  comp_pulse_a: assert property (
    compensationTrigger |-> $past(scanStrobe) ##1 !compensationTrigger)
    else $error("compensation pulse wrong");
  pos_read_a: assert property (
    regRdEn && regAddr == 8'h31 |=>
    regRdData == 8'($past(sliderFingerPosition) >> 8)) else $error("pos byte");
endmodule : slp_slider_props
bind slp_slider slp_slider_props #(.N(N), .TW(TW)) slp_slider_props_inst (
  .clk(clk), .rstn(rstn), .scanStrobe(scanStrobe), .regAddr(regAddr),
  .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
  .regRdData(regRdData), .sliderTouchPressure(sliderTouchPressure),
  .sliderFingerPosition(sliderFingerPosition), .sliderTouched(sliderTouched),
  .moveHigh(moveHigh), .moveLow(moveLow),
  .compensationTrigger(compensationTrigger));
`default_nettype wire

// file: testbench/slp_front_end.sv
// Sensing front-end model presenting tick differences per scan
`timescale 1ns/100ps
`default_nettype none
module slp_front_end #(
  parameter int N = 8,
  parameter int TW = 16
) (
  input wire logic clk,
  output logic scanStrobe,
  output logic [N*TW-1:0] tickDiff,
  output logic [N*TW-1:0] sensorTouchThreshold
);
  initial begin
    scanStrobe = 1'b0;
    tickDiff = '0;
    sensorTouchThreshold = '0;
  end
  // Levels scrambled after the strobe, only the strobe edge counts
  task automatic fire(input int t [N], input int h [N]);
    for (int i = 0; i < N; i++) begin
      tickDiff[i*TW +: TW] = TW'(t[i]);
      sensorTouchThreshold[i*TW +: TW] = TW'(h[i]);
    end
    scanStrobe = 1'b1;
    @(posedge clk);
    #1 scanStrobe = 1'b0;
    tickDiff = ~tickDiff;
    sensorTouchThreshold = ~sensorTouchThreshold;
  endtask : fire
endmodule : slp_front_end
`default_nettype wire

// file: testbench/test_slider_position_processing.sv
// Self-checking bench with a reference model of the slider block
`timescale 1ns/100ps
`default_nettype none
module test_slider_position_processing;
  import slp_pkg::*;
  localparam int N = 8;
  localparam int TW = 16;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic strobe, touched, mHi, mLo, avgHold, compTrig;
  logic [N*TW-1:0] ticks, thrs;
  slp_byte_t regAddr = 8'h00;
  slp_byte_t regWrData = 8'h00;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  slp_byte_t regRdData;
  logic [TW+$clog2(N)-1:0] pres;
  logic [15:0] pos;
  int err_total = 0, num_checks = 0, seed = 32'h2d32;
  int rm [0:255];
  int tk [N], th [N];
  int mT = 0, mV = 0, mPos = 0, mCnt = 0;
  slp_byte_t regs [8] = '{8'h29, 8'h2B, 8'h2C, 8'h2D, 8'h2E, 8'h2F,
    8'h30, 8'h40};
  slp_front_end #(.N(N), .TW(TW)) slp_front_end_inst (.clk(clk),
    .scanStrobe(strobe), .tickDiff(ticks), .sensorTouchThreshold(thrs));
  slp_slider #(.N(N), .TW(TW)) slp_slider_inst (.clk(clk), .rstn(rstn),
    .scanStrobe(strobe), .tickDiff(ticks), .sensorTouchThreshold(thrs),
    .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regRdData(regRdData), .sliderTouchPressure(pres),
    .sliderFingerPosition(pos), .sliderTouched(touched), .moveHigh(mHi),
    .moveLow(mLo), .averagingHold(avgHold), .compensationTrigger(compTrig));
  initial begin
    forever #20 clk = ~clk;
  end
  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input slp_byte_t a, input slp_byte_t d);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(posedge clk);
    #1 regWrEn = 1'b0;
    if (a inside {8'h29, [8'h2B:8'h30]}) rm[a] = d;
    @(posedge clk);
    #1;
  endtask : wr
  task automatic rd(input slp_byte_t a);
    slp_byte_t e;
    e = a == 8'h31 ? 8'(mPos >> 8) : a == 8'h32 ? 8'(mPos) : 8'(rm[a]);
    regAddr = a;
    regRdEn = 1'b1;
    @(posedge clk);
    #1 regRdEn = 1'b0;
    chk("regRdData", e, regRdData);
    @(posedge clk);
    #1;
  endtask : rd
  task automatic scan();
    int p, w, q, lim, d, trig, mh, ml;
    logic hold, neg;
    p = 0;
    w = 0;
    hold = 0;
    neg = 0;
    for (int i = 0; i < N; i++) begin
      if (tk[i] > th[i]) p += tk[i] - th[i];
      if (tk[i] > th[i]) w += i * (tk[i] - th[i]);
      hold |= tk[i] > rm[8'h2D] * 4;
      neg |= tk[i] < -rm[8'h2E] * 4;
    end
    if (p == 0) mT = 0;
    else if (p > rm[8'h29] * 4) mT = 1;
    lim = rm[8'h2F] == 0 ? 1 : rm[8'h2F];
    trig = neg && mCnt + 1 >= lim;
    mCnt = (!neg || trig) ? 0 : mCnt + 1;
    mh = 0;
    ml = 0;
    if (p == 0) mV = 0;
    else begin
      q = (rm[8'h2B] * 256 + rm[8'h2C]) / 32;
      d = q * w / p;
      if (d > q * (N - 1)) d = q * (N - 1);
      lim = q * (N - 1) * rm[8'h30] / 100;
      mh = mV && d - mPos > lim;
      ml = mV && mPos - d > lim;
      mV = 1;
      mPos = d;
    end
    slp_front_end_inst.fire(tk, th);
    // Trigger is a one-cycle pulse, so look right after the strobe edge
    chk("pressure", p, pres);
    chk("touched", mT, touched);
    chk("averagingHold", hold, avgHold);
    chk("compensation", trig, compTrig);
    repeat (38) @(posedge clk);
    #1;
    chk("position", mPos, pos);
    chk("moveHigh", mh, mHi);
    chk("moveLow", ml, mLo);
  endtask : scan
  initial begin
    #400000;
    err_total++;
    end_of_test();
  end
  initial begin
    rm = '{default: 0};
    rm[8'h29] = 3;
    rm[8'h2B] = 1;
    rm[8'h2C] = 8'h80;
    rm[8'h2D] = 8'h50;
    rm[8'h2E] = 8'h50;
    rm[8'h2F] = 1;
    rm[8'h30] = 2;
    repeat (6) @(posedge clk);
    #1 rstn = 1'b1;
    foreach (regs[j]) rd(regs[j]);
    wr(8'h31, 8'hA5);
    rd(8'h31);
    $display("Test reset values done");
    wr(8'h29, 8'h05);
    wr(8'h2D, 8'h40);
    wr(8'h2E, 8'h20);
    wr(8'h2F, 8'h02);
    wr(8'h30, 8'h05);
    foreach (regs[j]) rd(regs[j]);
    $display("Test register writes done");
    for (int k = 0; k < 16; k++) begin
      for (int i = 0; i < N; i++) begin
        th[i] = 200 + $unsigned($random(seed)) % 100;
        tk[i] = $random(seed) % 500;
        if (k % 4 == 2) tk[i] = (i == 3) ? th[i] + 5 : -5;
        if (k % 4 == 3) tk[i] = -5;
      end
      if (k == 8) wr(8'h2B, 8'h02);
      if (k == 8) wr(8'h2C, 8'h00);
      scan();
      rd(8'h31);
      rd(8'h32);
    end
    $display("Test scans done");
    end_of_test();
  end
endmodule : test_slider_position_processing
`default_nettype wire
